/* shared/msmm_consts.svh */
// Address map, loader and timing constants of the mode select and memory map block
`ifndef MSMM_CONSTS_SVH
`define MSMM_CONSTS_SVH
// Offsets inside a 4K page
`define MSMM_REG_END 12'h0a0
`define MSMM_RAM_SHR_LO 12'h0a0
`define MSMM_RAM_SHR_HI 12'h39f
`define MSMM_RAM_REMAP_LO 12'h300
`define MSMM_RAM_OWN_HI 12'h2ff
`define MSMM_EE_LO 12'hd80
// Full addresses
`define MSMM_BOOT_LO 16'hbe40
`define MSMM_BOOT_HI 16'hbfff
`define MSMM_VEC_LO 16'hffc0
`define MSMM_LOAD_BASE 16'h00a0
// Reset values of the mapping controls
`define MSMM_MAP_RST 8'h00
`define MSMM_EEMAP_RST 4'h0
// Loader figures
`define MSMM_RAM_BYTES 10'h300
`define MSMM_SYNC_STD 8'hff
`define MSMM_SYNC_ALT0 8'hf0
`define MSMM_SYNC_ALT1 8'hfd
// Bit periods in E clock cycles
`define MSMM_DIV_FAST 11'h100
`define MSMM_DIV_SLOW 11'h680
`define MSMM_DIV_ALT0 11'h0d0
`define MSMM_DIV_ALT1 11'h180
// Idle timeouts in bit times (ten bits a character)
`define MSMM_TMO_STD 8'h28
`define MSMM_TMO_ALT0 8'h31
`define MSMM_TMO_ALT1 8'had
`endif

/* shared/msmm_pkg.sv */
// Types of the mode select and memory map block
package msmm_pkg;
   // Operating modes
   typedef enum logic [1:0] {MSMM_BOOT, MSMM_TEST, MSMM_SINGLE, MSMM_EXPANDED} msmm_mode_t;
   // Loader sequence
   typedef enum logic [1:0] {MSMM_BL_OFF, MSMM_BL_SYNC, MSMM_BL_LOAD, MSMM_BL_DONE} msmm_bl_t;
endpackage

/* shared/msmm_ser_if.sv */
// Signals between the map block and its serial port
interface msmm_ser_if;
   logic [10:0] div;
   logic rx_line;
   logic [7:0] rx_data;
   logic rx_valid;
   logic [7:0] tx_data;
   logic tx_start;
   logic tx_line;
   logic tx_busy;
   logic bit_tick;
   modport link (output div, rx_line, tx_data, tx_start, input rx_data, rx_valid, tx_line, tx_busy, bit_tick);
   modport port (input div, rx_line, tx_data, tx_start, output rx_data, rx_valid, tx_line, tx_busy, bit_tick);
endinterface

/* test/mode_select_memory_map_bench.sv */
// Self-checking bench of the mode select and memory map block
module mode_select_memory_map_bench
   import msmm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, rx_pin = 1'b1, mode_select_a, mode_select_b;
   logic cpu_valid = 1'b0, cpu_write = 1'b0, cpu_direct = 1'b0, eeprom_cfg_en = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00, map_ctrl_data = 8'h00;
   logic [7:0] gpio_b_out = 8'h00, gpio_c_out = 8'h00, gpio_f_out = 8'h00;
   logic [7:0] gpio_b_dir = 8'h00, gpio_c_dir = 8'h00, gpio_f_dir = 8'h00;
   logic map_ctrl_wr = 1'b0, eeprom_map_wr = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
   logic [3:0] eeprom_map_data = 4'h0;
   msmm_mode_t op_mode;
   logic mode_ready, sel_regblk, sel_ram, sel_eeprom, sel_bootrom, sel_external, rw_n;
   logic tx_pin_out, tx_pin_oe, clk_run, boot_active, boot_jump;
   logic [7:0] ram_rdata, port_b_out, port_b_oe, port_f_out, port_f_oe, port_c_out, port_c_oe;
   int fail_count = 0, n_compared = 0, cycles = 0;
   wire [4:0] sel = {sel_regblk, sel_ram, sel_eeprom, sel_bootrom, sel_external};
   // Transmit wire with its external pull-up
   wire tx_line = tx_pin_oe ? 1'b0 : 1'b1;
   msmm_top dut (.*);
   msmm_ext_mem ext (.core_clk(core_clk), .port_b_out(port_b_out), .port_f_out(port_f_out),
      .port_c_out(port_c_out), .port_c_oe(port_c_oe), .rw_n(rw_n));
   // =====================================================
   // Clock and run limit
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         fail_count++;
         end_sim();
      end
   end
   // =====================================================
   // Shared tasks
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset(input logic [1:0] m, input msmm_mode_t exp);
      #1 rst = 1'b1;
      {mode_select_b, mode_select_a} = m;
      repeat (16) @(posedge core_clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 20 && mode_ready !== 1'b1; i++)
         @(posedge core_clk);
      #1 chk("mode", op_mode, exp);
   endtask
   task automatic acc(input logic w, input logic d, input logic [15:0] a, input logic [7:0] v);
      @(posedge core_clk);
      #1 {cpu_valid, cpu_write, cpu_direct, cpu_addr, cpu_wdata} = {1'b1, w, d, a, v};
      @(posedge core_clk);
      #1 cpu_valid = 1'b0;
   endtask
   task automatic ctl(input logic s, input logic k, input logic mw, input logic ew);
      @(posedge core_clk);
      #1 {stop_req, wake_req, map_ctrl_wr, eeprom_map_wr} = {s, k, mw, ew};
      @(posedge core_clk);
      #1 {stop_req, wake_req, map_ctrl_wr, eeprom_map_wr} = 4'h0;
   endtask
   task automatic send(input logic [7:0] b, input int p);
      for (int i = 0; i < 10; i++)
      begin
         @(posedge core_clk);
         #1 rx_pin = (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i - 1]);
         repeat (p - 1) @(posedge core_clk);
      end
   endtask
   task automatic echo(input logic [7:0] exp, input int p);
      logic [7:0] got;
      for (int i = 0; i < 4000 && tx_line !== 1'b0; i++)
         @(posedge core_clk);
      repeat (p / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (p) @(posedge core_clk);
         got[i] = tx_line;
      end
      chk("echo", got, exp);
   endtask
   // =====================================================
   // Scenarios
   task automatic t_single();
      do_reset(2'b10, MSMM_SINGLE);
      {gpio_b_out, gpio_c_out, gpio_f_out, gpio_b_dir, gpio_c_dir, gpio_f_dir} = 48'h3cc3a5_f00fff;
      acc(1'b1, 1'b0, 16'h8000, 8'h00);
      chk("ext", sel, 5'h00);
      chk("pb", {port_b_out, port_b_oe}, 16'h3cf0);
      chk("pf", {port_f_out, port_f_oe}, 16'ha5ff);
      chk("pc", {port_c_out, port_c_oe}, 16'hc30f);
      acc(1'b0, 1'b0, 16'hbe40, 8'h00);
      chk("rom", sel, 5'h00);
      acc(1'b0, 1'b0, 16'h009f, 8'h00);
      chk("reg", sel, 5'h10);
      acc(1'b1, 1'b1, 16'hffc5, 8'hc3);
      acc(1'b0, 1'b0, 16'h00c5, 8'h00);
      chk("direct", {3'h0, sel, ram_rdata}, 16'h08c3);
      acc(1'b1, 1'b0, 16'h0300, 8'h77);
      acc(1'b0, 1'b0, 16'h0300, 8'h00);
      chk("alias", {3'h0, sel, ram_rdata}, 16'h0877);
      acc(1'b0, 1'b0, 16'h03a0, 8'h00);
      chk("gap", sel, 5'h00);
      acc(1'b0, 1'b0, 16'h0d80, 8'h00);
      chk("ee off", sel, 5'h00);
      eeprom_cfg_en = 1'b1;
      acc(1'b0, 1'b0, 16'h0fff, 8'h00);
      chk("ee on", sel, 5'h04);
      ctl(1'b1, 1'b0, 1'b0, 1'b0);
      chk("stop", clk_run, 1'b0);
      acc(1'b1, 1'b0, 16'h0300, 8'h11);
      ctl(1'b0, 1'b1, 1'b0, 1'b0);
      clk_en = 1'b0;
      acc(1'b1, 1'b0, 16'h0300, 8'h22);
      clk_en = 1'b1;
      acc(1'b0, 1'b0, 16'h0300, 8'h00);
      chk("kept", {clk_run, ram_rdata}, 16'h0177);
      {map_ctrl_data, eeprom_map_data} = 12'h213;
      ctl(1'b0, 1'b0, 1'b1, 1'b1);
      acc(1'b0, 1'b0, 16'h1000, 8'h00);
      chk("reg page", sel, 5'h10);
      acc(1'b0, 1'b0, 16'h2000, 8'h00);
      chk("ram page", sel, 5'h08);
      acc(1'b0, 1'b0, 16'h0000, 8'h00);
      chk("old page", sel, 5'h00);
      acc(1'b0, 1'b0, 16'h3d80, 8'h00);
      chk("ee page", sel, 5'h04);
   endtask
   task automatic t_exp();
      do_reset(2'b11, MSMM_EXPANDED);
      acc(1'b1, 1'b0, 16'h8234, 8'h3c);
      chk("wr bus", {port_b_out, port_f_out}, 16'h8234);
      chk("wr dir", {7'h0, rw_n, port_c_out}, 16'h003c);
      @(posedge core_clk);
      #1 chk("ext mem", ext.mem[16'h8234], 8'h3c);
      acc(1'b0, 1'b0, 16'h8321, 8'h00);
      chk("rd", {2'h0, sel, rw_n, port_c_oe}, 16'h0300);
      acc(1'b0, 1'b0, 16'h0010, 8'h00);
      chk("prio", sel, 5'h10);
      do_reset(2'b01, MSMM_TEST);
      acc(1'b0, 1'b0, 16'h8000, 8'h00);
      chk("test ext", sel, 5'h01);
   endtask
   task automatic t_boot();
      do_reset(2'b00, MSMM_BOOT);
      send(8'hff, 256);
      repeat (3072) @(posedge core_clk);
      fork
         send(8'h96, 256);
         echo(8'h96, 256);
      join
      fork
         send(8'h3c, 256);
         echo(8'h3c, 256);
      join
      // Jump pulse stands one cycle: look at it mid-cycle
      for (int i = 0; i < 14000 && boot_jump !== 1'b1; i++)
         @(negedge core_clk);
      chk("jump", boot_jump, 1'b1);
      acc(1'b0, 1'b0, 16'h00a0, 8'h00);
      chk("load0", ram_rdata, 8'h96);
      acc(1'b0, 1'b0, 16'h00a1, 8'h00);
      chk("load1", {boot_active, ram_rdata}, 16'h003c);
      acc(1'b0, 1'b0, 16'hbe40, 8'h00);
      chk("rom lo", sel, 5'h02);
      acc(1'b0, 1'b0, 16'hbe3f, 8'h00);
      chk("rom out", sel, 5'h00);
      acc(1'b0, 1'b0, 16'hfffe, 8'h00);
      chk("vector", sel, 5'h02);
   endtask
   task automatic t_alt();
      do_reset(2'b00, MSMM_BOOT);
      // alternative sync byte selects another bit rate
      send(8'hf0, 256);
      fork
         send(8'h5a, 208);
         echo(8'h5a, 208);
      join
      acc(1'b0, 1'b0, 16'h00a0, 8'h00);
      chk("alt load", {boot_active, ram_rdata}, 16'h015a);
   endtask
   initial
   begin
      t_single();
      t_exp();
      t_boot();
      t_alt();
      end_sim();
   end
endmodule

/* test/msmm_ext_mem.sv */
// External memory model on the expansion bus
module msmm_ext_mem
(
   input wire logic core_clk,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_f_out,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_oe,
   input wire logic rw_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   always @(posedge core_clk)
      if (!rw_n && port_c_oe == 8'hff)
         mem[{port_b_out, port_f_out}] <= port_c_out;
endmodule

/* test/msmm_sva.sv */
// Checker of mode capture, map decode, bus and loader outputs
module msmm_sva
   import msmm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cpu_valid,
   input wire logic cpu_write,
   input wire logic cpu_direct,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic stop_req,
   input wire logic wake_req,
   input wire msmm_mode_t op_mode,
   input wire logic mode_ready,
   input wire logic sel_regblk,
   input wire logic sel_ram,
   input wire logic sel_eeprom,
   input wire logic sel_bootrom,
   input wire logic sel_external,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_f_out,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_oe,
   input wire logic rw_n,
   input wire logic tx_pin_out,
   input wire logic tx_pin_oe,
   input wire logic clk_run,
   input wire logic boot_jump
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Accesses taken with a full address and a settled mode
   wire take = clk_en && clk_run && cpu_valid && !cpu_direct && mode_ready;
   wire ext_take = take && op_mode == MSMM_EXPANDED && cpu_addr[15:12] == 4'h8;
   wire vec_take = take && op_mode == MSMM_BOOT && cpu_addr[15:6] == 10'h3ff;
   // =====================================================
   // Assertions
   sel_onehot_a: assert property ($onehot0({sel_regblk, sel_ram, sel_eeprom, sel_bootrom, sel_external}))
      else $error("more than one target selected");
   boot_off_a: assert property (mode_ready && op_mode inside {MSMM_SINGLE, MSMM_EXPANDED} |-> !sel_bootrom)
      else $error("boot ROM selected in a normal mode");
   single_bus_a: assert property (mode_ready && op_mode == MSMM_SINGLE |-> rw_n && !sel_external)
      else $error("external bus active in single chip mode");
   exp_addr_a: assert property (ext_take && cpu_write |=> {port_b_out, port_f_out} == $past(cpu_addr)
      && port_c_out == $past(cpu_wdata) && port_c_oe == 8'hff)
      else $error("expansion bus address or data wrong");
   exp_dir_a: assert property (ext_take |=> rw_n == !$past(cpu_write) && sel_external)
      else $error("read write pin wrong on external cycle");
   vec_boot_a: assert property (vec_take |=> sel_bootrom)
      else $error("vector fetch not served by boot ROM");
   jump_pulse_a: assert property (boot_jump |=> !boot_jump)
      else $error("jump pulse longer than one cycle");
   tx_drain_a: assert property (!tx_pin_out && (!tx_pin_oe || op_mode == MSMM_BOOT))
      else $error("transmit pin driven high or outside bootstrap");
   stop_halt_a: assert property (clk_en && stop_req && !wake_req |=> !clk_run)
      else $error("clocks not halted on stop");
   mode_hold_a: assert property (mode_ready |=> mode_ready && $stable(op_mode))
      else $error("latched mode changed");
   // Main scenarios reached
   cover property (ext_take && cpu_write);
   cover property (vec_take);
   cover property (boot_jump);
   cover property ($fell(clk_run));
endmodule
bind msmm_top msmm_sva chk_i (.*);

/* verilog/msmm_serial.sv */
// Asynchronous serial receiver and transmitter used by the loader
module msmm_serial
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   msmm_ser_if.port sp
);
   logic rx_busy_reg;
   logic [10:0] rx_cnt_reg;
   logic [3:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic [10:0] tx_cnt_reg;
   logic [9:0] tx_sh_reg;
   logic [3:0] tx_left_reg;
   logic [10:0] tk_cnt_reg;

   // Receiver: start check at half bit, then eight data bits and stop
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_busy_reg <= 1'b0;
         rx_cnt_reg <= 11'h000;
         rx_bit_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         sp.rx_data <= 8'h00;
         sp.rx_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         sp.rx_valid <= 1'b0;
         if (!rx_busy_reg)
         begin
            if (!sp.rx_line)
            begin
               rx_busy_reg <= 1'b1;
               rx_cnt_reg <= {1'b0, sp.div[10:1]};
               rx_bit_reg <= 4'h0;
            end
         end
         else if (rx_cnt_reg != 11'h000)
            rx_cnt_reg <= rx_cnt_reg - 11'h001;
         else
         begin
            rx_cnt_reg <= sp.div - 11'h001;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0)
               rx_busy_reg <= !sp.rx_line; // False start drops back
            else if (rx_bit_reg <= 4'h8)
               rx_shift_reg <= {sp.rx_line, rx_shift_reg[7:1]};
            else
            begin
               rx_busy_reg <= 1'b0;
               sp.rx_data <= rx_shift_reg;
               sp.rx_valid <= sp.rx_line; // Framing error discards
            end
         end
      end
   end

   // Transmitter shifts start, data and stop out at the bit rate
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_cnt_reg <= 11'h000;
         tx_sh_reg <= 10'h3ff;
         tx_left_reg <= 4'h0;
      end
      else if (clk_en)
      begin
         if (sp.tx_start && tx_left_reg == 4'h0)
         begin
            tx_sh_reg <= {1'b1, sp.tx_data, 1'b0};
            tx_left_reg <= 4'ha;
            tx_cnt_reg <= sp.div - 11'h001;
         end
         else if (tx_left_reg != 4'h0)
         begin
            if (tx_cnt_reg != 11'h000)
               tx_cnt_reg <= tx_cnt_reg - 11'h001;
            else
            begin
               tx_cnt_reg <= sp.div - 11'h001;
               tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
               tx_left_reg <= tx_left_reg - 4'h1;
            end
         end
      end
   end
   assign sp.tx_line = tx_sh_reg[0];
   assign sp.tx_busy = tx_left_reg != 4'h0;

   // Free running bit time tick for the idle timeout
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         tk_cnt_reg <= 11'h000;
      else if (clk_en)
         tk_cnt_reg <= (tk_cnt_reg == 11'h000) ? sp.div - 11'h001 : tk_cnt_reg - 11'h001;
   end
   assign sp.bit_tick = clk_en && tk_cnt_reg == 11'h000;
endmodule

/* verilog/msmm_top.sv */
// Operating mode capture, address map decode, expansion bus and boot loader
module msmm_top
   import msmm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic mode_select_a,
   input wire logic mode_select_b,
   input wire logic rx_pin,
   input wire logic cpu_valid,
   input wire logic cpu_write,
   input wire logic cpu_direct,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] gpio_b_out,
   input wire logic [7:0] gpio_b_dir,
   input wire logic [7:0] gpio_c_out,
   input wire logic [7:0] gpio_c_dir,
   input wire logic [7:0] gpio_f_out,
   input wire logic [7:0] gpio_f_dir,
   input wire logic map_ctrl_wr,
   input wire logic [7:0] map_ctrl_data,
   input wire logic eeprom_map_wr,
   input wire logic [3:0] eeprom_map_data,
   input wire logic eeprom_cfg_en,
   input wire logic stop_req,
   input wire logic wake_req,
   output msmm_mode_t op_mode,
   output logic mode_ready,
   output logic sel_regblk,
   output logic sel_ram,
   output logic sel_eeprom,
   output logic sel_bootrom,
   output logic sel_external,
   output logic [7:0] ram_rdata,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] port_f_out,
   output logic [7:0] port_f_oe,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_oe,
   output logic rw_n,
   output logic tx_pin_out,
   output logic tx_pin_oe,
   output logic clk_run,
   output logic boot_active,
   output logic boot_jump
);
`include "msmm_consts.svh"

   msmm_ser_if ser ();

   logic [2:0] ma_sync_reg;
   logic [2:0] mb_sync_reg;
   logic [2:0] rx_sync_reg;
   logic [1:0] settle_reg;
   logic rx_level_reg;
   logic [7:0] map_ctrl_reg;
   logic [3:0] eeprom_map_reg;
   logic [7:0] ram_mem [0:767];
   msmm_bl_t bl_state_reg;
   logic slow_rate_reg;
   logic [10:0] div_reg;
   logic [7:0] tmo_reg;
   logic [7:0] idle_reg;
   logic [9:0] load_cnt_reg;
   logic run;
   logic expanded;
   logic [15:0] eff_addr;
   logic [3:0] page;
   logic [11:0] off;
   logic hit_reg;
   logic hit_ram;
   logic hit_ee;
   logic hit_boot;
   logic [9:0] ram_idx;
   logic load_wr;
   logic [11:0] load_off;
   logic [9:0] load_idx;

   // Map, decode, RAM, bus and loader state advance only when enabled and not stopped
   assign run = clk_en && clk_run;
   assign expanded = op_mode == MSMM_EXPANDED || op_mode == MSMM_TEST;

   // ==========================================================
   // Pin synchronisers and mode capture
   // ==========================================================

   // Three stage synchronisers for the mode and receive pins
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ma_sync_reg <= 3'h0;
         mb_sync_reg <= 3'h0;
         rx_sync_reg <= 3'h7;
         rx_level_reg <= 1'b1;
      end
      else if (clk_en)
      begin
         ma_sync_reg <= {ma_sync_reg[1:0], mode_select_a};
         mb_sync_reg <= {mb_sync_reg[1:0], mode_select_b};
         rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
         if (rx_sync_reg[1] == rx_sync_reg[2])
            rx_level_reg <= rx_sync_reg[2];
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         settle_reg <= 2'h0;
         mode_ready <= 1'b0;
         op_mode <= MSMM_SINGLE;
      end
      else if (clk_en && !mode_ready)
      begin
         if (settle_reg != 2'h3)
            settle_reg <= settle_reg + 2'h1;
         else if (ma_sync_reg[1] == ma_sync_reg[2] && mb_sync_reg[1] == mb_sync_reg[2])
         begin
            mode_ready <= 1'b1;
            case ({mb_sync_reg[2], ma_sync_reg[2]})
               2'h0: op_mode <= MSMM_BOOT;
               2'h1: op_mode <= MSMM_TEST;
               2'h2: op_mode <= MSMM_SINGLE;
               default: op_mode <= MSMM_EXPANDED;
            endcase
         end
      end
   end

   // ==========================================================
   // Mapping controls and stop mode
   // ==========================================================

   // RAM page high nibble, register page low nibble
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         map_ctrl_reg <= `MSMM_MAP_RST;
         eeprom_map_reg <= `MSMM_EEMAP_RST;
      end
      else if (run)
      begin
         if (map_ctrl_wr)
            map_ctrl_reg <= map_ctrl_data;
         if (eeprom_map_wr)
            eeprom_map_reg <= eeprom_map_data;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         clk_run <= 1'b1;
      else if (clk_en)
      begin
         if (wake_req)
            clk_run <= 1'b1;
         else if (stop_req)
            clk_run <= 1'b0;
      end
   end

   // ==========================================================
   // Address decode
   // ==========================================================

   // Effective address and hit terms for the current request
   always_comb
   begin
      eff_addr = cpu_direct ? {8'h00, cpu_addr[7:0]} : cpu_addr;
      if (op_mode == MSMM_BOOT && eff_addr >= `MSMM_VEC_LO)
         eff_addr = {2'h2, eff_addr[13:0]};
      page = eff_addr[15:12];
      off = eff_addr[11:0];
      hit_reg = page == map_ctrl_reg[3:0] && off < `MSMM_REG_END;
      if (map_ctrl_reg[7:4] == map_ctrl_reg[3:0])
      begin
         hit_ram = page == map_ctrl_reg[7:4] && off >= `MSMM_RAM_SHR_LO && off <= `MSMM_RAM_SHR_HI;
         ram_idx = (off >= `MSMM_RAM_REMAP_LO) ? 10'(off - `MSMM_RAM_REMAP_LO) : off[9:0];
      end
      else
      begin
         hit_ram = page == map_ctrl_reg[7:4] && off <= `MSMM_RAM_OWN_HI;
         ram_idx = off[9:0];
      end
      hit_ee = eeprom_cfg_en && page == eeprom_map_reg && off >= `MSMM_EE_LO;
      hit_boot = op_mode == MSMM_BOOT && eff_addr >= `MSMM_BOOT_LO && eff_addr <= `MSMM_BOOT_HI;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_regblk <= 1'b0;
         sel_ram <= 1'b0;
         sel_eeprom <= 1'b0;
         sel_bootrom <= 1'b0;
         sel_external <= 1'b0;
      end
      else if (run)
      begin
         sel_regblk <= cpu_valid && hit_reg;
         sel_ram <= cpu_valid && !hit_reg && hit_ram;
         sel_eeprom <= cpu_valid && !hit_reg && !hit_ram && hit_ee;
         sel_bootrom <= cpu_valid && !hit_reg && !hit_ram && !hit_ee && hit_boot;
         // no external cycles in single chip
         sel_external <= cpu_valid && expanded && !(hit_reg || hit_ram || hit_ee || hit_boot);
      end
   end

   // ==========================================================
   // On-chip RAM
   // ==========================================================

   // Loader writes win over processor writes; nothing changes in stop
   always_ff @(posedge core_clk)
   begin
      if (run)
      begin
         if (load_wr)
            ram_mem[load_idx] <= ser.rx_data;
         else if (cpu_valid && cpu_write && hit_ram && !hit_reg)
            ram_mem[ram_idx] <= cpu_wdata;
      end
   end

   // Registered read data
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         ram_rdata <= 8'h00;
      else if (run && cpu_valid && !cpu_write && hit_ram)
         ram_rdata <= ram_mem[ram_idx];
   end

   // ==========================================================
   // Expansion bus ports
   // ==========================================================

   // address and data on B, F, C
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         port_b_out <= 8'h00;
         port_b_oe <= 8'h00;
         port_f_out <= 8'h00;
         port_f_oe <= 8'h00;
         port_c_out <= 8'h00;
         port_c_oe <= 8'h00;
         rw_n <= 1'b1;
      end
      else if (run && mode_ready)
      begin
         if (expanded)
         begin
            port_b_oe <= 8'hff;
            port_f_oe <= 8'hff;
            if (cpu_valid)
            begin
               port_b_out <= eff_addr[15:8];
               port_f_out <= eff_addr[7:0];
               port_c_out <= cpu_wdata;
            end
            port_c_oe <= (cpu_valid && cpu_write) ? 8'hff : 8'h00;
            rw_n <= !(cpu_valid && cpu_write);
         end
         else
         begin
            port_b_out <= gpio_b_out;
            port_b_oe <= gpio_b_dir;
            port_f_out <= gpio_f_out;
            port_f_oe <= gpio_f_dir;
            port_c_out <= gpio_c_out;
            port_c_oe <= gpio_c_dir;
            rw_n <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Boot loader
   // ==========================================================

   assign load_wr = bl_state_reg == MSMM_BL_LOAD && ser.rx_valid;
   assign ser.rx_line = rx_level_reg;
   assign ser.div = div_reg;
   assign ser.tx_data = ser.rx_data;
   assign ser.tx_start = load_wr;
   // byte n lands where a read of 00A0 plus n finds it in the default map
   assign load_off = `MSMM_RAM_SHR_LO + {2'h0, load_cnt_reg};
   assign load_idx = (load_off >= `MSMM_RAM_REMAP_LO) ? 10'(load_off - `MSMM_RAM_REMAP_LO) : load_off[9:0];

   // Loader sequence: sync, load, jump
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         bl_state_reg <= MSMM_BL_OFF;
         slow_rate_reg <= 1'b0;
         div_reg <= `MSMM_DIV_FAST;
         tmo_reg <= `MSMM_TMO_STD;
         idle_reg <= 8'h00;
         load_cnt_reg <= 10'h000;
         boot_jump <= 1'b0;
      end
      else if (run)
      begin
         boot_jump <= 1'b0;
         case (bl_state_reg)
            MSMM_BL_OFF:
               if (mode_ready && op_mode == MSMM_BOOT)
                  bl_state_reg <= MSMM_BL_SYNC;
            MSMM_BL_SYNC:
               if (ser.rx_valid)
               begin
                  if (ser.rx_data == `MSMM_SYNC_STD)
                  begin
                     bl_state_reg <= MSMM_BL_LOAD;
                     tmo_reg <= `MSMM_TMO_STD;
                  end
                  else if (ser.rx_data == `MSMM_SYNC_ALT0 && !slow_rate_reg)
                  begin
                     bl_state_reg <= MSMM_BL_LOAD;
                     div_reg <= `MSMM_DIV_ALT0;
                     tmo_reg <= `MSMM_TMO_ALT0;
                  end
                  else if (ser.rx_data == `MSMM_SYNC_ALT1 && !slow_rate_reg)
                  begin
                     bl_state_reg <= MSMM_BL_LOAD;
                     div_reg <= `MSMM_DIV_ALT1;
                     tmo_reg <= `MSMM_TMO_ALT1;
                  end
                  else
                  begin
                     // Wrong guess: try the other standard rate
                     slow_rate_reg <= !slow_rate_reg;
                     div_reg <= slow_rate_reg ? `MSMM_DIV_FAST : `MSMM_DIV_SLOW;
                  end
                  idle_reg <= 8'h00;
               end
            MSMM_BL_LOAD:
            begin
               // end on count or idle timeout
               if (load_wr && load_cnt_reg == `MSMM_RAM_BYTES - 10'h001)
               begin
                  bl_state_reg <= MSMM_BL_DONE;
                  boot_jump <= 1'b1;
               end
               else if (!load_wr && idle_reg >= tmo_reg)
               begin
                  bl_state_reg <= MSMM_BL_DONE;
                  boot_jump <= 1'b1;
               end
               if (load_wr)
               begin
                  load_cnt_reg <= load_cnt_reg + 10'h001;
                  idle_reg <= 8'h00;
               end
               else if (ser.bit_tick && !ser.tx_busy)
                  idle_reg <= idle_reg + 8'h01;
            end
            MSMM_BL_DONE:
               bl_state_reg <= MSMM_BL_DONE;
            default:
               bl_state_reg <= MSMM_BL_OFF;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_pin_out <= 1'b0;
         tx_pin_oe <= 1'b0;
         boot_active <= 1'b0;
      end
      else if (run)
      begin
         tx_pin_out <= 1'b0; // Pin only ever pulled low
         tx_pin_oe <= !ser.tx_line;
         boot_active <= bl_state_reg == MSMM_BL_SYNC || bl_state_reg == MSMM_BL_LOAD;
      end
   end

   // Serial port at the selected bit rate
   msmm_serial u_serial
   (
      .core_clk (core_clk),
      .rst (rst),
      .clk_en (run),
      .sp (ser.port)
   );
endmodule
